// file: hw/flash_program_erase_ctrl.v
// Flash program and erase controller with APB register access.
// Assumes an APB master on clock and a flash array that performs the operation
// flagged on its strobes for as long as they stand.
//
// Contract
// RULE1 - Program and erase timing runs from a 1MHz tick divided from the system clock.
// RULE2 - Software programs divisor 100 when the 100MHz oscillator drives the system.
// RULE3 - Software loads unlock code 2 before any write or erase; only the unlock field of the start write counts.
// RULE4 - Any unlock value other than 2 locks, or keeps locked, the flash.
// RULE5 - Starting an operation while unlock is not 2 sets the access-fail flag.
// RULE6 - Writes are 128 bits wide; target address bits 3:0 are ignored.
// RULE7 - Array is 64 pages of 512 128-bit words, starting at 0x1000_0000.
// RULE8 - Software writes only erased locations; others fail.
// RULE9 - Four data words form 128 bits, highest register most significant.
// RULE10 - Write-start bit launches a write and clears itself when finished.
// RULE11 - Write completion sets done; interrupt raised when done enable set.
// RULE12 - Errors set access-fail; interrupt raised when its enable set.
// RULE13 - Software polls pending until zero before starting an operation.
// RULE14 - Page erase starts from page-erase bit with erase code 0x55.
// RULE15 - Page erase ignores address bits 12:0.
// RULE16 - Pending high during page erase; pending and page-erase bit cleared at end.
// RULE17 - Mass erase starts from mass-erase bit with erase code 0xAA.
// RULE18 - Pending high during mass erase; pending and mass-erase bit cleared at end.
// RULE19 - Erase completion sets done, access-fail on error, interrupts per enable.
// RULE20 - Software re-locks the flash after each operation.
// RULE21 - Instruction fetches continue while the instance is programmed.
// RULE22 - Software avoids erasing the flash it executes from.
// RULE23 - A locked refusal leaves the array alone, clears start, no pending.
// RULE24 - Clock divisor is 8 bits at 7:0, reset 0x64.
// RULE25 - Unlock code is bits 31:28 of control, reset 0.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`include "flash_ctrl_defines.vh"

module flash_program_erase_ctrl #(
    parameter [15:0] PAGE_ERASE_US = 16'h4E20,
    parameter [15:0] MASS_ERASE_US = 16'h4E20
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Flash array side
    output reg [31:0] fl_addr,
    output reg [127:0] fl_wdata,
    output reg fl_write,
    output reg fl_page_erase,
    output reg fl_mass_erase,
    output wire fl_op_tick,
    input wire fl_error,
    // System side
    output wire flash_irq,
    output wire fetch_stall
);

// ==========================================================
// Reset release
reg [1:0] rst_pipe_r;
wire rst_sync_b;

always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        rst_pipe_r <= 2'b00;
    end else begin
        rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
end
assign rst_sync_b = rst_pipe_r[1];

// ==========================================================
// Registers
reg [31:0] flash_target_addr_r;
reg [7:0] flash_clock_divisor_reg_r;
reg [3:0] unlock_r;
reg [7:0] erase_code_r;
reg lowv_r;
reg write_start_r;
reg page_erase_start_r;
reg mass_erase_start_r;
reg done_flag_r;
reg access_fail_flag_r;
reg done_ie_r;
reg fail_ie_r;
reg [31:0] word_r [0:3];

wire busy_w;
wire op_done_w;
wire op_tick_w;

// ==========================================================
// APB decode
wire access_w;
wire wr_en_w;
reg mapped_w;
reg [2:0] sel_word_w;

assign access_w = psel && penable;
assign wr_en_w = access_w && pwrite;
assign pready = 1'b1;
assign pslverr = access_w && !mapped_w;

always @* begin
    mapped_w = 1'b1;
    sel_word_w = 3'b100;
    if (paddr == `OFS_WORD0) begin
        sel_word_w = 3'b000;
    end else if (paddr == `OFS_WORD1) begin
        sel_word_w = 3'b001;
    end else if (paddr == `OFS_WORD2) begin
        sel_word_w = 3'b010;
    end else if (paddr == `OFS_WORD3) begin
        sel_word_w = 3'b011;
    end else if (paddr != `OFS_TARGET_ADDR && paddr != `OFS_CLOCK_DIV &&
                 paddr != `OFS_OP_CONTROL && paddr != `OFS_IRQ_FLAGS) begin
        mapped_w = 1'b0;
    end
end

// ==========================================================
// Operation request from a control write
wire ctl_wr_w;
wire [3:0] new_unlock_w;
wire [7:0] new_code_w;
wire req_wr_w;
wire req_page_w;
wire req_mass_w;
wire any_req_w;
wire unlocked_w;
wire [31:0] page_addr_w;
wire [31:0] word_addr_w;
wire in_range_w;
wire code_ok_w;
wire launch_w;
wire refuse_w;

assign ctl_wr_w = wr_en_w && (paddr == `OFS_OP_CONTROL);
assign new_unlock_w = pwdata[`CTL_UNLOCK_HI:`CTL_UNLOCK_LO];
assign new_code_w = pwdata[`CTL_CODE_HI:`CTL_CODE_LO];
assign req_wr_w = ctl_wr_w && pwdata[`CTL_WRITE_BIT];
assign req_page_w = ctl_wr_w && pwdata[`CTL_PAGE_BIT];
assign req_mass_w = ctl_wr_w && pwdata[`CTL_MASS_BIT];
// A start during a running operation is dropped; software polls pending first
assign any_req_w = (req_wr_w || req_page_w || req_mass_w) && !busy_w;
assign unlocked_w = (new_unlock_w == `UNLOCK_CODE); // RULE4
assign word_addr_w = {flash_target_addr_r[31:`WORD_ALIGN_BITS], 4'h0}; // RULE6
assign page_addr_w = {flash_target_addr_r[31:`PAGE_ALIGN_BITS], 13'h0000}; // RULE15
assign in_range_w = (flash_target_addr_r >= `FLASH_BASE) &&
                    (flash_target_addr_r < `FLASH_LIMIT); // RULE7
assign code_ok_w = req_mass_w ? (new_code_w == `MASS_ERASE_CODE) : // RULE17
                   req_page_w ? (new_code_w == `PAGE_ERASE_CODE) : // RULE14
                   1'b1;
assign launch_w = any_req_w && unlocked_w && code_ok_w && (req_mass_w || in_range_w);
assign refuse_w = any_req_w && !launch_w; // RULE5

// ==========================================================
// Operation timer
reg [15:0] op_len_w;

always @* begin
    if (req_mass_w) begin
        op_len_w = MASS_ERASE_US;
    end else if (req_page_w) begin
        op_len_w = PAGE_ERASE_US;
    end else begin
        op_len_w = `WRITE_TIME_US;
    end
end

op_clock_divider u_divider (
    .clock(clock),
    .rst_sync_b(rst_sync_b),
    .divisor(flash_clock_divisor_reg_r),
    .op_tick(op_tick_w)
);

op_timer u_timer (
    .clock(clock),
    .rst_sync_b(rst_sync_b),
    .op_tick(op_tick_w),
    .start(launch_w),
    .length(op_len_w),
    .busy(busy_w),
    .done(op_done_w)
);

assign fl_op_tick = op_tick_w; // RULE1

// ==========================================================
// Flash strobes; fl_error sampled while an operation runs
reg op_err_r;

always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        fl_addr <= 32'h0000_0000;
        fl_wdata <= 128'h0;
        fl_write <= 1'b0;
        fl_page_erase <= 1'b0;
        fl_mass_erase <= 1'b0;
        op_err_r <= 1'b0;
    end else if (launch_w) begin
        // Mass over page over write when several starts arrive together
        fl_mass_erase <= req_mass_w;
        fl_page_erase <= req_page_w && !req_mass_w;
        fl_write <= req_wr_w && !req_page_w && !req_mass_w; // RULE10
        fl_addr <= req_page_w ? page_addr_w : word_addr_w;
        fl_wdata <= {word_r[3], word_r[2], word_r[1], word_r[0]}; // RULE9
        op_err_r <= 1'b0;
    end else if (op_done_w) begin
        fl_write <= 1'b0;
        fl_page_erase <= 1'b0;
        fl_mass_erase <= 1'b0;
    end else if (busy_w && fl_error) begin
        op_err_r <= 1'b1; // RULE8
    end
end

// ==========================================================
// Control register
always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        unlock_r <= 4'h0; // RULE25
        erase_code_r <= 8'h00;
        lowv_r <= 1'b0;
        write_start_r <= 1'b0;
        page_erase_start_r <= 1'b0;
        mass_erase_start_r <= 1'b0;
    end else begin
        if (ctl_wr_w) begin
            unlock_r <= new_unlock_w; // RULE4
            erase_code_r <= new_code_w;
            lowv_r <= pwdata[`CTL_LOWV_BIT];
        end
        if (launch_w) begin
            mass_erase_start_r <= req_mass_w;
            page_erase_start_r <= req_page_w && !req_mass_w;
            write_start_r <= req_wr_w && !req_page_w && !req_mass_w;
        end else if (op_done_w || refuse_w) begin
            write_start_r <= 1'b0; // RULE10
            page_erase_start_r <= 1'b0; // RULE16
            mass_erase_start_r <= 1'b0; // RULE18
        end
    end
end

// ==========================================================
// Other software registers
integer i;

always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        flash_target_addr_r <= `RST_TARGET_ADDR;
        flash_clock_divisor_reg_r <= `RST_CLOCK_DIV; // RULE24
        done_ie_r <= 1'b0;
        fail_ie_r <= 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            word_r[i] <= 32'h0000_0000;
        end
    end else if (wr_en_w) begin
        if (paddr == `OFS_TARGET_ADDR) begin
            flash_target_addr_r <= pwdata;
        end else if (paddr == `OFS_CLOCK_DIV) begin
            flash_clock_divisor_reg_r <= pwdata[7:0];
        end else if (paddr == `OFS_IRQ_FLAGS) begin
            done_ie_r <= pwdata[`IRQ_DONE_EN_BIT];
            fail_ie_r <= pwdata[`IRQ_FAIL_EN_BIT];
        end else if (!sel_word_w[2]) begin
            word_r[sel_word_w[1:0]] <= pwdata;
        end
    end
end

// ==========================================================
// Sticky flags: write one to clear, a same-cycle event wins
wire clr_done_w;
wire clr_fail_w;
wire set_done_w;
wire set_fail_w;

assign clr_done_w = wr_en_w && (paddr == `OFS_IRQ_FLAGS) && pwdata[`IRQ_DONE_BIT];
assign clr_fail_w = wr_en_w && (paddr == `OFS_IRQ_FLAGS) && pwdata[`IRQ_FAIL_BIT];
assign set_done_w = op_done_w; // RULE11 RULE19
assign set_fail_w = refuse_w || (op_done_w && (op_err_r || fl_error)); // RULE12 RULE19

always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        done_flag_r <= 1'b0;
        access_fail_flag_r <= 1'b0;
    end else begin
        done_flag_r <= (done_flag_r && !clr_done_w) || set_done_w;
        access_fail_flag_r <= (access_fail_flag_r && !clr_fail_w) || set_fail_w; // RULE5
    end
end

assign flash_irq = (done_flag_r && done_ie_r) || (access_fail_flag_r && fail_ie_r); // RULE12
// Reads of the array are never held off by a running operation
assign fetch_stall = 1'b0; // RULE21

// ==========================================================
// Read data
always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
        prdata <= 32'h0000_0000;
        if (paddr == `OFS_TARGET_ADDR) begin
            prdata <= flash_target_addr_r;
        end else if (paddr == `OFS_CLOCK_DIV) begin
            prdata <= {24'h00_0000, flash_clock_divisor_reg_r};
        end else if (paddr == `OFS_OP_CONTROL) begin
            prdata[`CTL_UNLOCK_HI:`CTL_UNLOCK_LO] <= unlock_r;
            prdata[`CTL_LOWV_BIT] <= lowv_r;
            // Pending spans the done cycle so it falls with the start bits
            prdata[`CTL_PEND_BIT] <= busy_w || op_done_w; // RULE16 RULE18 RULE23
            prdata[`CTL_CODE_HI:`CTL_CODE_LO] <= erase_code_r;
            prdata[`CTL_PAGE_BIT] <= page_erase_start_r;
            prdata[`CTL_MASS_BIT] <= mass_erase_start_r;
            prdata[`CTL_WRITE_BIT] <= write_start_r;
        end else if (paddr == `OFS_IRQ_FLAGS) begin
            prdata[`IRQ_DONE_BIT] <= done_flag_r;
            prdata[`IRQ_FAIL_BIT] <= access_fail_flag_r;
            prdata[`IRQ_DONE_EN_BIT] <= done_ie_r;
            prdata[`IRQ_FAIL_EN_BIT] <= fail_ie_r;
        end else if (!sel_word_w[2]) begin
            prdata <= word_r[sel_word_w[1:0]];
        end
    end
end

endmodule // flash_program_erase_ctrl

// file: hw/flash_ctrl_defines.vh
// Register map, field layout, reset values and operation timing of the flash controller.
// Assumes inclusion by the controller files only; definitions only.
`ifndef FLASH_CTRL_DEFINES_VH
`define FLASH_CTRL_DEFINES_VH

// ==========================================================
// Register byte offsets
`define OFS_TARGET_ADDR 8'h00
`define OFS_CLOCK_DIV 8'h04
`define OFS_OP_CONTROL 8'h08
`define OFS_IRQ_FLAGS 8'h24
`define OFS_WORD0 8'h30
`define OFS_WORD1 8'h34
`define OFS_WORD2 8'h38
`define OFS_WORD3 8'h3C

// ==========================================================
// Reset values
`define RST_TARGET_ADDR 32'h1000_0000
`define RST_CLOCK_DIV 8'h64

// ==========================================================
// Control register fields
`define CTL_WRITE_BIT 0
`define CTL_MASS_BIT 1
`define CTL_PAGE_BIT 2
`define CTL_CODE_LO 8
`define CTL_CODE_HI 15
`define CTL_PEND_BIT 24
`define CTL_LOWV_BIT 25
`define CTL_UNLOCK_LO 28
`define CTL_UNLOCK_HI 31
`define UNLOCK_CODE 4'h2
`define PAGE_ERASE_CODE 8'h55
`define MASS_ERASE_CODE 8'hAA

// ==========================================================
// Interrupt register fields
`define IRQ_DONE_BIT 0
`define IRQ_FAIL_BIT 1
`define IRQ_DONE_EN_BIT 8
`define IRQ_FAIL_EN_BIT 9

// ==========================================================
// Flash geometry
`define FLASH_BASE 32'h1000_0000
`define FLASH_LIMIT 32'h1008_0000
`define WORD_ALIGN_BITS 4
`define PAGE_ALIGN_BITS 13

// ==========================================================
// Operation timing, in microseconds (ticks of the operation clock)
`define WRITE_TIME_US 16'h0014

`endif

// file: hw/op_clock_divider.v
// Divides the system clock down to the operation tick, one pulse per divisor period.
// Assumes a synchronous active-low reset from the top module.
module op_clock_divider (
    // Clock and reset
    input wire clock,
    input wire rst_sync_b,
    // Divisor and tick
    input wire [7:0] divisor,
    output reg op_tick
);

reg [7:0] count_r;
wire [7:0] last_w;

// Divisor of zero behaves as one, so the tick never stops
assign last_w = (divisor == 8'h00) ? 8'h00 : divisor - 8'h01;

always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        count_r <= 8'h00;
        op_tick <= 1'b0;
    end else if (count_r >= last_w) begin
        count_r <= 8'h00;
        op_tick <= 1'b1; // RULE1
    end else begin
        count_r <= count_r + 8'h01;
        op_tick <= 1'b0;
    end
end

endmodule // op_clock_divider

// file: hw/op_timer.v
// Times one program or erase operation in operation ticks.
// Assumes start only while idle; length counted in ticks of the divided clock.
module op_timer (
    // Clock and reset
    input wire clock,
    input wire rst_sync_b,
    // Control
    input wire op_tick,
    input wire start,
    input wire [15:0] length,
    // Status
    output reg busy,
    output reg done
);

reg [15:0] left_r;

always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
        left_r <= 16'h0000;
        busy <= 1'b0;
        done <= 1'b0;
    end else begin
        done <= 1'b0;
        if (start && !busy) begin
            left_r <= (length == 16'h0000) ? 16'h0001 : length;
            busy <= 1'b1;
        end else if (busy && op_tick) begin
            if (left_r == 16'h0001) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
            left_r <= left_r - 16'h0001;
        end
    end
end

endmodule // op_timer

// file: sim/flash_ctrl_chk.sv
// Port checker for the flash program and erase controller.
// Assumes one clock domain; attached by the bind after the module.
module flash_ctrl_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // Array side
    input wire logic [31:0] fl_addr,
    input wire logic [127:0] fl_wdata,
    input wire logic fl_write,
    input wire logic fl_page_erase,
    input wire logic fl_mass_erase,
    input wire logic fl_op_tick,
    input wire logic fetch_stall
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [7:0] tick_cnt;
    wire op_any = fl_write | fl_page_erase | fl_mass_erase;
    // Ticks seen during one write
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) tick_cnt <= 8'h00;
        else if (!fl_write) tick_cnt <= 8'h00;
        else if (fl_op_tick) tick_cnt <= tick_cnt + 8'h01;
    end
    sequence s_locked_start;
        psel && penable && pwrite && paddr == 8'h08 && pwdata[31:28] != 4'h2 && |pwdata[2:0];
    endsequence
    sequence s_write_runs;
        fl_write [*8];
    endsequence
    property p_wr_align; fl_write |-> fl_addr[3:0] == 4'h0; endproperty
    property p_pg_align; fl_page_erase |-> fl_addr[12:0] == 13'h0000; endproperty
    property p_range;
        (fl_write || fl_page_erase) |-> fl_addr >= 32'h1000_0000 && fl_addr < 32'h1008_0000;
    endproperty
    property p_one_op; $onehot0({fl_write, fl_page_erase, fl_mass_erase}); endproperty
    property p_lock; s_locked_start |=> !$rose(op_any); endproperty
    property p_hold;
        fl_write && $past(fl_write) |-> $stable(fl_wdata) && $stable(fl_addr);
    endproperty
    property p_ticks; $fell(fl_write) |-> tick_cnt inside {[19:21]}; endproperty
    property p_run; $rose(fl_write) |-> s_write_runs; endproperty
    property p_fetch; !fetch_stall; endproperty
    a_wr_align: assert property (p_wr_align) else $error("write address not aligned");
    a_pg_align: assert property (p_pg_align) else $error("erase address not aligned");
    a_range: assert property (p_range) else $error("address outside array");
    a_one_op: assert property (p_one_op) else $error("two operations at once");
    a_lock: assert property (p_lock) else $error("locked start ran");
    a_hold: assert property (p_hold) else $error("write data moved");
    a_ticks: assert property (p_ticks) else $error("write tick count wrong");
    a_run: assert property (p_run) else $error("write strobe too short");
    a_fetch: assert property (p_fetch) else $error("fetch stalled");
endmodule // flash_ctrl_chk

bind flash_program_erase_ctrl flash_ctrl_chk u_chk (.clock(clock), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_write(fl_write),
    .fl_page_erase(fl_page_erase), .fl_mass_erase(fl_mass_erase),
    .fl_op_tick(fl_op_tick), .fetch_stall(fetch_stall));

// file: sim/flash_array_model.sv
// Behavioural flash array: tracks written words, erases pages and the whole array.
// Assumes strobes stand for the whole operation; error reported on reprogramming.
module flash_array_model (
    // Clock
    input wire logic clock,
    // Controller side
    input wire logic [31:0] fl_addr,
    input wire logic [127:0] fl_wdata,
    input wire logic fl_write,
    input wire logic fl_page_erase,
    input wire logic fl_mass_erase,
    output logic fl_error
);
    timeunit 1ns;
    timeprecision 1ps;
    bit used [32768];
    logic wr_d = 1'b0;
    logic bad_r = 1'b0;
    initial fl_error = 1'b0;
    always @(posedge clock) begin
        wr_d <= fl_write;
        if (!fl_write) begin
            bad_r <= 1'b0;
        end else if (!wr_d) begin
            bad_r <= used[fl_addr[18:4]];
            used[fl_addr[18:4]] <= 1'b1;
        end
        fl_error <= fl_write & bad_r;
        // Page of 512 words
        if (fl_page_erase) begin
            for (int i = 0; i < 512; i++) used[{fl_addr[18:13], i[8:0]}] <= 1'b0;
        end
        if (fl_mass_erase) begin
            for (int i = 0; i < 32768; i++) used[i] <= 1'b0;
        end
    end
endmodule // flash_array_model

// file: sim/testbench.sv
// Self-checking bench: APB register tasks driving write, erase and lock sequences.
// Assumes the array model and checker are compiled before this file.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [31:0] fl_addr;
    wire [127:0] fl_wdata;
    wire fl_write;
    wire fl_page_erase;
    wire fl_mass_erase;
    wire fl_op_tick;
    wire fl_error;
    wire flash_irq;
    wire fetch_stall;
    int err_total = 0;
    int check_count = 0;
    int starts = 0;
    int s0;
    logic [31:0] rd;
    logic perr;
    logic any_d = 1'b0;
    logic [1:0] ien = 2'b00;
    logic [127:0] wdata_exp = 128'h4444_0004_3333_0003_2222_0002_1111_0001;
    always #2.5 clock = ~clock;
    // Counts operation starts seen at the array
    always @(posedge clock) begin
        any_d <= fl_write | fl_page_erase | fl_mass_erase;
        if ((fl_write | fl_page_erase | fl_mass_erase) === 1'b1 && !any_d) starts++;
    end
    flash_program_erase_ctrl #(.PAGE_ERASE_US(16'h0003), .MASS_ERASE_US(16'h0003)) dut (
        .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_write(fl_write),
        .fl_page_erase(fl_page_erase), .fl_mass_erase(fl_mass_erase),
        .fl_op_tick(fl_op_tick), .fl_error(fl_error), .flash_irq(flash_irq),
        .fetch_stall(fetch_stall));
    flash_array_model array (.clock(clock), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
        .fl_write(fl_write), .fl_page_erase(fl_page_erase), .fl_mass_erase(fl_mass_erase),
        .fl_error(fl_error));
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, only the watchdog ends the wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick_gap(input int exp);
        int n;
        n = 0;
        do @(posedge clock); while (fl_op_tick !== 1'b1 && ++n < 300);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (fl_op_tick !== 1'b1 && n < 300);
        check(n, exp);
    endtask
    // Starts an operation and follows it to the end
    task automatic run_op(input logic [31:0] ctl, input logic [2:0] strb,
                          input logic [31:0] a, input logic [1:0] flags);
        int n;
        n = 0;
        s0 = starts;
        apb(1'b1, 8'h08, ctl);
        @(posedge clock);
        #1;
        check({fl_mass_erase, fl_page_erase, fl_write}, strb);
        if (strb[1:0] != 2'b00) check(fl_addr, a);
        if (strb[0]) check(fl_wdata, wdata_exp);
        apb(1'b0, 8'h08, 32'h0000_0000);
        check(rd[24], |strb);
        while (rd[24] === 1'b1 && n < 200) begin
            apb(1'b0, 8'h08, 32'h0000_0000);
            n++;
        end
        check(rd[24:0] & 25'h100_0007, 25'h000_0000);
        check(starts - s0, |strb);
        apb(1'b0, 8'h24, 32'h0000_0000);
        check(rd[1:0], flags);
        check(flash_irq, |(flags & ien));
        apb(1'b1, 8'h24, {22'h00_0000, ien, 8'h03});
        #1;
        check(flash_irq, 1'b0);
        apb(1'b1, 8'h08, 32'h0000_0000);
    endtask
    initial begin
        #100000;
        err_total++;
        results();
    end
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check(rd, 32'h1000_0000);
        apb(1'b0, 8'h04, 32'h0000_0000);
        check(rd, 32'h0000_0064);
        apb(1'b0, 8'h08, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check({perr, rd}, {1'b1, 32'h0000_0000});
        tick_gap(100);
        apb(1'b1, 8'h04, 32'hFFFF_FF03);
        apb(1'b0, 8'h04, 32'h0000_0000);
        check(rd, 32'h0000_0003);
        tick_gap(3);
        // Masked refusal: flag set, no interrupt
        run_op(32'h3000_0001, 3'b000, 32'h0, 2'b10);
        ien = 2'b11;
        apb(1'b1, 8'h24, 32'h0000_0300);
        apb(1'b1, 8'h00, 32'h1000_0123);
        for (int i = 0; i < 4; i++) apb(1'b1, 8'h30 + 8'(4 * i), wdata_exp[32 * i +: 32]);
        run_op(32'h2000_0001, 3'b001, 32'h1000_0120, 2'b01);
        apb(1'b1, 8'h08, 32'h2000_0000);
        apb(1'b0, 8'h08, 32'h0000_0000);
        check(rd, 32'h2000_0000);
        run_op(32'h0000_5504, 3'b000, 32'h0, 2'b10);
        run_op(32'h2000_0001, 3'b001, 32'h1000_0120, 2'b11);
        run_op(32'h2000_AA04, 3'b000, 32'h0, 2'b10);
        apb(1'b1, 8'h00, 32'h1000_1ABC);
        run_op(32'h2000_5504, 3'b010, 32'h1000_0000, 2'b01);
        apb(1'b1, 8'h00, 32'h1000_0127);
        run_op(32'h2000_0001, 3'b001, 32'h1000_0120, 2'b01);
        // Bench runs no code from the array, so the whole array may go
        run_op(32'h2000_AA02, 3'b100, 32'h0, 2'b01);
        run_op(32'h2000_0001, 3'b001, 32'h1000_0120, 2'b01);
        results();
    end
endmodule // testbench
